//--- common/dsw_pkg.sv
// Shared constants and types for the two-bank setting switch with serial slave port
package dsw_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int  CLK_PERIOD_NS = 25;       // 40 MHz system clock
  localparam real BUSY_TIME_MS  = 3.6;      // Address refusal after programming
  // Least time: round up, small guard keeps float noise from adding a cycle
  localparam int  BUSY_CYC      =
    int'($ceil(BUSY_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS) - 1.0e-6));
  localparam int  BUSY_W        = 18;       // Counter width, holds BUSY_CYC

  // ----------------------------------------------------------------
  // Command codes and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NV0    = 8'h00;  // Setting bank 0
  localparam logic [7:0] CMD_NV1    = 8'h01;  // Setting bank 1
  localparam logic [7:0] CMD_PINS   = 8'hff;  // Input pin levels, read only
  localparam logic [4:0] MUXCMD_PFX = 5'h1f;  // Upper five bits of override cmds
  localparam logic [7:0] MUXCMD_NV0 = 8'hf8;  // Outputs from bank 0
  localparam logic [7:0] MUXCMD_NV1 = 8'hfc;  // Outputs from bank 1
  localparam logic [1:0] MUXCMD_PIN = 2'h2;   // Low bits: outputs from inputs
  localparam int         EXTRA_BIT  = 5;      // Extra output bit in a bank
  localparam int         NV_W       = 6;      // Stored bits per bank
  localparam int         OUT_W      = 5;      // Multiplexed outputs
  localparam logic [5:0] NV_RESET   = 6'h00;  // Delivered contents
  localparam logic [3:0] BYTE_BITS  = 4'h8;   // Bits per byte
  localparam logic [3:0] TX_LAST    = 4'h7;   // Index of last bit sent
  localparam logic [2:0] IDX_ADDR   = 3'h0;   // Byte index: slave address
  localparam logic [2:0] IDX_CMD    = 3'h1;   // Byte index: command
  localparam logic [2:0] IDX_DAT0   = 3'h2;   // Byte index: first data
  localparam logic [2:0] IDX_DAT1   = 3'h3;   // Byte index: second data
  localparam logic [2:0] IDX_OVER   = 3'h4;   // Byte index: one too many
  // Upper slave address bits; value is arbitrary
  localparam logic [4:0] ADDR_HI_DEF = 5'h15;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OVR_NONE, OVR_NV0, OVR_NV1, OVR_PINS} dsw_ovr_t;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} dsw_state_t;

  // All asynchronous pin inputs, synchronised as one group
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic       sel0;
    logic       sel1;
    logic       supply_ok;
    logic [1:0] addr;
    logic [4:0] mux_in;
  } dsw_pins_t;

  localparam int PINS_W = $bits(dsw_pins_t);

endpackage : dsw_pkg

//--- logic/dsw_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module dsw_sync
  import dsw_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------
  // One flop pair per bit
  // ----------------------------------------------------------------
  logic [W-1:0] meta_r;  // First stage, read only by the second

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      // Reset to high: idle bus and pulled-up pins read high
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          meta_r[gi] <= 1'b1;
          q[gi]      <= 1'b1;
        end
        else
        begin
          meta_r[gi] <= d[gi];
          q[gi]      <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule : dsw_sync

//--- logic/dsw_top.sv
// Two-bank setting switch: serial slave port, bank storage, output select
`timescale 1ns/1ps
module dsw_top
  import dsw_pkg::*;
#(
  parameter int         BUSY_CYCLES = BUSY_CYC,    // Shorten for simulation
  parameter logic [4:0] ADDR_HI     = ADDR_HI_DEF  // Fixed slave address part
)(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic [1:0] ADDR_PINS,
  input  wire logic [4:0] MUX_IN,
  input  wire logic       SEL0,
  input  wire logic       SEL1,
  input  wire logic       WP,
  input  wire logic       SUPPLY_OK,
  output logic      [4:0] MUX_OUT,
  output logic            EXTRA_OUT
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  dsw_pins_t pins_raw;   // Raw pin group
  dsw_pins_t pins_s;     // Synchronised pin group

  assign pins_raw = '{scl: SCL_IN, sda: SDA_IN, wp: WP, sel0: SEL0, sel1: SEL1,
                      supply_ok: SUPPLY_OK, addr: ADDR_PINS, mux_in: MUX_IN};

  dsw_sync #(.W(PINS_W)) u_sync (
    .clk   (CLK),
    .rst_b (RST_B),
    .d     (pins_raw),
    .q     (pins_s)
  );

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  logic scl_d_r;     // Previous synchronised clock
  logic sda_d_r;     // Previous synchronised data
  logic scl_rise;    // Clock rising edge
  logic scl_fall;    // Clock falling edge
  logic start_det;   // Start condition
  logic stop_det;    // Stop condition

  // Edge history, taken from the second synchroniser stage only
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= pins_s.scl;
      sda_d_r <= pins_s.sda;
    end
  end

  assign scl_rise  = pins_s.scl & ~scl_d_r;
  assign scl_fall  = ~pins_s.scl & scl_d_r;
  // Data moving while clock high is a control condition, not data
  assign start_det = pins_s.scl & scl_d_r & sda_d_r & ~pins_s.sda;
  assign stop_det  = pins_s.scl & scl_d_r & ~sda_d_r & pins_s.sda;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dsw_state_t        state_r;       // Bus machine state
  logic [3:0]        bit_cnt_r;     // Bits moved in current byte
  logic [2:0]        byte_idx_r;    // Byte position in transfer, saturating
  logic [7:0]        shift_r;       // Receive shifter
  logic [7:0]        tx_r;          // Transmit shifter
  logic              rw_r;          // Transfer direction, 1 = read
  logic              acked_r;       // Last received byte was acknowledged
  logic              mack_r;        // Master acknowledged last read byte
  logic              mux_seen_r;    // Override command seen in this transfer
  logic [7:0]        cmd_r;         // Stored command code, read pointer
  dsw_ovr_t          ovr_r;         // Stored output-source override
  logic [1:0]        pend_cnt_r;    // Data bytes waiting for stop
  logic              pend_bank_r;   // Bank for the first waiting byte
  logic [NV_W-1:0]   pend0_r;       // First waiting byte
  logic [NV_W-1:0]   pend1_r;       // Second waiting byte
  logic              abort_r;       // Too many bytes: drop all writes
  logic              sda_oe_r;      // Pulling data low
  logic [NV_W-1:0]   nv_r [2];      // Setting banks
  logic [BUSY_W-1:0] busy_cnt_r;    // Programming refusal counter
  logic              busy;          // Programming in progress
  logic              commit;        // Program waiting bytes now
  logic              ack_nxt;       // Answer for the byte just received
  logic [7:0]        rd_byte;       // Byte a read would return now

  assign busy = (busy_cnt_r != '0);

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  // Pointer chooses the returned register; upper bits always zero
  always_comb
  begin
    unique case (cmd_r)
      CMD_NV0:  rd_byte = {2'h0, nv_r[0]};
      CMD_NV1:  rd_byte = {2'h0, nv_r[1]};
      default:  rd_byte = {3'h0, pins_s.mux_in};
    endcase
  end

  // ----------------------------------------------------------------
  // Acknowledge decision for a received byte
  // ----------------------------------------------------------------
  always_comb
  begin
    ack_nxt = 1'b0;
    unique case (byte_idx_r)
      IDX_ADDR:
        // Own address refused while programming runs
        ack_nxt = (shift_r[7:1] == {ADDR_HI, pins_s.addr}) && !busy;
      IDX_CMD:
        // Register codes and any override pattern; the rest reserved
        ack_nxt = (shift_r == CMD_NV0) || (shift_r == CMD_NV1) ||
                  (shift_r[7:3] == MUXCMD_PFX);
      IDX_DAT0, IDX_DAT1:
        // Data only after a bank code, never after an override command
        ack_nxt = !mux_seen_r && !pins_s.wp &&
                  (cmd_r != CMD_PINS);
      default:
        ack_nxt = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus machine
  // ----------------------------------------------------------------
  // Start and stop win over any bit activity in the same cycle
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      state_r     <= ST_IDLE;
      bit_cnt_r   <= '0;
      byte_idx_r  <= IDX_ADDR;
      shift_r     <= '0;
      tx_r        <= '0;
      rw_r        <= 1'b0;
      acked_r     <= 1'b0;
      mack_r      <= 1'b0;
      mux_seen_r  <= 1'b0;
      cmd_r       <= CMD_NV0;
      ovr_r       <= OVR_NONE;
      pend_cnt_r  <= '0;
      pend_bank_r <= 1'b0;
      pend0_r     <= '0;
      pend1_r     <= '0;
      abort_r     <= 1'b0;
      sda_oe_r    <= 1'b0;
    end
    else if (start_det)
    begin
      // Fresh transfer; a repeated start drops unprogrammed bytes
      state_r    <= ST_RX;
      bit_cnt_r  <= '0;
      byte_idx_r <= IDX_ADDR;
      mux_seen_r <= 1'b0;
      pend_cnt_r <= '0;
      abort_r    <= 1'b0;
      sda_oe_r   <= 1'b0;
    end
    else if (stop_det)
    begin
      // Bytes are programmed in this cycle by the bank process
      state_r    <= ST_IDLE;
      pend_cnt_r <= '0;
      abort_r    <= 1'b0;
      sda_oe_r   <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          // Not addressed or refused: wait for start or stop
          sda_oe_r <= 1'b0;
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            // Sample while clock high, one bit per pulse
            shift_r   <= {shift_r[6:0], pins_s.sda};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (scl_fall && (bit_cnt_r == BYTE_BITS))
          begin
            // Ninth pulse: drive answer from this fall to the next
            sda_oe_r <= ack_nxt;
            acked_r  <= ack_nxt;
            state_r  <= ST_RX_ACK;
            if (byte_idx_r == IDX_ADDR)
              rw_r <= shift_r[0];
            else if (byte_idx_r == IDX_CMD && ack_nxt)
            begin
              if (shift_r[7:3] == MUXCMD_PFX)
              begin
                mux_seen_r <= 1'b1;
                // Input-pin code also fits the override pattern; it still sets the pointer
                if (shift_r == CMD_PINS)
                  cmd_r <= CMD_PINS;
                if (shift_r == MUXCMD_NV0)
                  ovr_r <= OVR_NV0;
                else if (shift_r == MUXCMD_NV1)
                  ovr_r <= OVR_NV1;
                else if (shift_r[1:0] == MUXCMD_PIN)
                  ovr_r <= OVR_PINS;
                else
                  ovr_r <= OVR_NONE;
              end
              else
                cmd_r <= shift_r;
            end
            else if (byte_idx_r == IDX_DAT0 && ack_nxt)
            begin
              pend0_r     <= shift_r[NV_W-1:0];
              pend_bank_r <= cmd_r[0];
              pend_cnt_r  <= 2'h1;
              cmd_r       <= cmd_r ^ 8'h01;
            end
            else if (byte_idx_r == IDX_DAT1 && ack_nxt)
            begin
              pend1_r    <= shift_r[NV_W-1:0];
              pend_cnt_r <= 2'h2;
              cmd_r      <= cmd_r ^ 8'h01;
            end
            else if (byte_idx_r == IDX_OVER)
              abort_r <= 1'b1;
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_r <= '0;
            if (byte_idx_r != IDX_OVER)
              byte_idx_r <= byte_idx_r + 3'h1;
            if (!acked_r)
            begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_IDLE;
            end
            else if (byte_idx_r == IDX_ADDR && rw_r)
            begin
              // Read: first bit goes out right after the answer
              tx_r     <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
              state_r  <= ST_TX;
            end
            else
            begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_r == TX_LAST)
            begin
              // Release for the master's answer; pointer moves on unless it holds the input-pin code
              sda_oe_r <= 1'b0;
              state_r  <= ST_TX_ACK;
              if (cmd_r != CMD_PINS)
                cmd_r <= cmd_r ^ 8'h01;
            end
            else
            begin
              tx_r      <= {tx_r[6:0], 1'b0};
              sda_oe_r  <= ~tx_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
            mack_r <= ~pins_s.sda;
          else if (scl_fall)
          begin
            bit_cnt_r <= '0;
            if (mack_r)
            begin
              tx_r     <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
              state_r  <= ST_TX;
            end
            else
            begin
              // Last byte: leave data released so the master can stop
              sda_oe_r <= 1'b0;
              state_r  <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Setting banks
  // ----------------------------------------------------------------
  // Program only at stop, unprotected, with the supply good;
  // protect pin is checked again here in case it rose mid-transfer
  assign commit = stop_det && (pend_cnt_r != 2'h0) && !abort_r &&
                  !pins_s.wp &&
                  pins_s.supply_ok;

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      nv_r[0] <= NV_RESET;
      nv_r[1] <= NV_RESET;
    end
    else if (commit)
    begin
      nv_r[pend_bank_r] <= pend0_r;
      if (pend_cnt_r == 2'h2)
        nv_r[~pend_bank_r] <= pend1_r;
    end
  end

  // ----------------------------------------------------------------
  // Programming refusal timer
  // ----------------------------------------------------------------
  // Counts down from the refusal time; address is nacked while nonzero
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      busy_cnt_r <= '0;
    else if (commit)
      busy_cnt_r <= BUSY_CYCLES[BUSY_W-1:0];
    else if (busy)
      busy_cnt_r <= busy_cnt_r - 1'b1;
  end

  // ----------------------------------------------------------------
  // Output source selection
  // ----------------------------------------------------------------
  logic use_pins;   // Multiplexed outputs follow input pins
  logic bank;       // Bank feeding outputs and extra output

  // Stored override first; sel0 only when none is stored, sel1 also picks the bank under the input-pin override
  always_comb
  begin
    unique case (ovr_r)
      OVR_NV0:
      begin
        use_pins = 1'b0;
        bank     = 1'b0;
      end
      OVR_NV1:
      begin
        use_pins = 1'b0;
        bank     = 1'b1;
      end
      OVR_PINS:
      begin
        use_pins = 1'b1;
        bank     = ~pins_s.sel1;
      end
      default:
      begin
        use_pins = pins_s.sel0;
        bank     = ~pins_s.sel1;
      end
    endcase
  end

  // Registered outputs; extra output holds while inputs drive outputs
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      MUX_OUT   <= NV_RESET[OUT_W-1:0];
      EXTRA_OUT <= NV_RESET[EXTRA_BIT];
    end
    else
    begin
      MUX_OUT <= use_pins ? pins_s.mux_in : nv_r[bank][OUT_W-1:0];
      if (!use_pins)
        EXTRA_OUT <= nv_r[bank][EXTRA_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Data pin drive
  // ----------------------------------------------------------------
  // Open drain: the level driven is always low, only the enable moves
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      SDA_OUT <= 1'b0;
      SDA_OE  <= 1'b0;
    end
    else
    begin
      SDA_OUT <= 1'b0;
      SDA_OE  <= sda_oe_r;
    end
  end

endmodule : dsw_top

//--- tb/dsw_master.sv
// Bus master model that clocks bytes in and out of the switch
`timescale 1ns/1ps
module dsw_master
  import dsw_pkg::*;
(
  input  wire logic CLK,
  input  wire logic SDA,
  output logic      scl_r,
  output logic      sda_r
);
  localparam int H = 20;  // Half bus period in clocks, slow against the sync delay

  // Released lines float high through the pull-up
  initial
  begin
    scl_r = 1'b1;
    sda_r = 1'b1;
  end

  // Data moves only while the clock is low; sampled at the end of high
  task automatic bit_x(input logic b, output logic s);
    scl_r <= 1'b0;
    repeat (H / 2) @(posedge CLK);
    sda_r <= b;
    repeat (H / 2) @(posedge CLK);
    scl_r <= 1'b1;
    repeat (H) @(posedge CLK);
    s = SDA;
  endtask : bit_x

  // Start from an idle bus only
  task automatic st();
    sda_r <= 1'b0;
    repeat (H) @(posedge CLK);
  endtask : st

  // Stop: data rises while the clock is high
  task automatic sp();
    scl_r <= 1'b0;
    repeat (H / 2) @(posedge CLK);
    sda_r <= 1'b0;
    repeat (H / 2) @(posedge CLK);
    scl_r <= 1'b1;
    repeat (H) @(posedge CLK);
    sda_r <= 1'b1;
    repeat (H) @(posedge CLK);
  endtask : sp

  // Eight bits MSB first, then the ninth bit r; ack when the line is low
  task automatic xb(input logic [7:0] d, input logic r, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(r, s);
    ack = ~s;
  endtask : xb
endmodule : dsw_master

//--- tb/dsw_props.sv
// Checker of bus pin timing and reset state of the switch
`timescale 1ns/1ps
module dsw_props
  import dsw_pkg::*;
#(
  parameter int         BUSY_CYCLES = BUSY_CYC,
  parameter logic [4:0] ADDR_HI     = ADDR_HI_DEF
)(
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic       SCL_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic [4:0] MUX_OUT,
  input wire logic       EXTRA_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_drive_low: assert property (SDA_OUT == 1'b0)
    else $error("data drive level not low");
  a_reset_idle: assert property (disable iff (1'b0)
    !RST_B |=> !SDA_OE && MUX_OUT == 5'h00 && !EXTRA_OUT)
    else $error("outputs not cleared in reset");
  a_release_quiet: assert property ($rose(RST_B) |-> !SDA_OE [*3])
    else $error("data driven right after reset");
  a_out_release: assert property ($rose(RST_B) |-> MUX_OUT == 5'h00 && !EXTRA_OUT)
    else $error("outputs not zero at reset release");
  a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("data drive changed while clock high");
  a_ack_held: assert property ($rose(SCL_IN) && SDA_OE |-> SDA_OE [*8])
    else $error("low drive not held over clock high");
  a_ack_after_fall: assert property ($rose(SDA_OE) |-> $past(SCL_IN, 3) == 1'b0)
    else $error("drive began without a clock fall");
  a_free_after_fall: assert property ($fell(SDA_OE) |-> !SCL_IN && !$past(SCL_IN, 3))
    else $error("drive released without a clock fall");

  c_ack: cover property ($rose(SDA_OE));
  c_extra: cover property ($changed(EXTRA_OUT));
  c_mux: cover property ($changed(MUX_OUT));
endmodule : dsw_props

bind dsw_top dsw_props #(.BUSY_CYCLES(BUSY_CYCLES), .ADDR_HI(ADDR_HI)) u_props (
  .CLK, .RST_B, .SCL_IN, .SDA_OUT, .SDA_OE, .MUX_OUT, .EXTRA_OUT);

//--- tb/test_dsw_top.sv
// Self-checking bench: bus transfers and pin selection of the switch
`timescale 1ns/1ps
module test_dsw_top;
  import dsw_pkg::*;
  localparam int BUSY = 2000;  // Shortened refusal time, longer than one address byte
  logic       clk;
  logic       rst_b;
  logic       sel0;
  logic       sel1;
  logic       wp;
  logic       sup_ok;
  logic [4:0] mux_in;
  logic [4:0] mux_out;
  logic       extra;
  logic       sda_out;
  logic       sda_oe;
  logic       scl;
  logic       sda_m;
  logic [7:0] r0;
  logic [7:0] r1;
  logic [4:0] a;  // Ack per byte: address, command, data 0..2
  int         mismatches;
  int         comparisons;
  int         cyc;
  wire        sda_w = sda_m & ~(sda_oe & ~sda_out);  // Pull-up wire level
  logic [7:0] ovr [4] = '{8'hf8, 8'hfc, 8'hfa, 8'hf9};  // Override codes
  logic [4:0] ovx [4] = '{5'h13, 5'h15, 5'h0c, 5'h15};  // Outputs expected
  logic [3:0] ovb     = 4'h1;                           // Extra expected

  dsw_top #(.BUSY_CYCLES(BUSY)) uut (
    .CLK(clk), .RST_B(rst_b), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .ADDR_PINS(2'h2), .MUX_IN(mux_in), .SEL0(sel0), .SEL1(sel1),
    .WP(wp), .SUPPLY_OK(sup_ok), .MUX_OUT(mux_out), .EXTRA_OUT(extra));
  dsw_master m (.CLK(clk), .SDA(sda_w), .scl_r(scl), .sda_r(sda_m));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // Write transfer: address, then n bytes from the top of v, then stop
  task automatic wr(input logic [31:0] v, input int n);
    logic [7:0] q;
    a = 5'h00;
    m.st();
    m.xb({ADDR_HI_DEF, 2'h2, 1'b0}, 1'b1, q, a[4]);
    for (int i = 0; i < n; i++)
      m.xb(v[31-8*i -: 8], 1'b1, q, a[3-i]);
    m.sp();
  endtask : wr

  // Set pointer by command c, then read two bytes
  task automatic rdp(input logic [7:0] c, input logic [7:0] e0, input logic [7:0] e1);
    logic k;
    wr({c, 24'h0}, 1);
    m.st();
    m.xb({ADDR_HI_DEF, 2'h2, 1'b1}, 1'b1, r0, k);
    m.xb(8'hff, 1'b0, r0, k);
    m.xb(8'hff, 1'b1, r1, k);
    m.sp();
    chk(r0, e0);
    chk(r1, e1);
  endtask : rdp

  // Let pin changes pass the synchroniser, then look at the outputs
  task automatic outs(input logic [4:0] em, input logic ex);
    repeat (10) @(posedge clk);
    chk({3'h0, mux_out}, {3'h0, em});
    chk({7'h0, extra}, {7'h0, ex});
  endtask : outs

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    sel0 = 1'b0;
    sel1 = 1'b1;
    wp = 1'b0;
    sup_ok = 1'b1;
    mux_in = 5'h13;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    outs(5'h00, 1'b0);
    wr(32'h00ea_0000, 2);
    chk({3'h0, a}, 8'h1c);
    outs(5'h0a, 1'b1);
    wr(32'h0, 0);
    chk({3'h0, a}, 8'h00);
    repeat (BUSY) @(posedge clk);
    wr(32'h0115_3300, 3);
    chk({3'h0, a}, 8'h1e);
    repeat (BUSY) @(posedge clk);
    sel1 <= 1'b0;
    outs(5'h15, 1'b0);
    sel1 <= 1'b1;
    rdp(8'h00, 8'h33, 8'h15);
    wp <= 1'b1;
    wr(32'h003f_0000, 2);
    chk({3'h0, a}, 8'h18);
    wp <= 1'b0;
    sup_ok <= 1'b0;
    wr(32'h003f_0000, 2);
    sup_ok <= 1'b1;
    repeat (BUSY) @(posedge clk);
    rdp(8'h00, 8'h33, 8'h15);
    wr(32'h0500_0000, 1);
    chk({3'h0, a}, 8'h10);
    rdp(8'hff, 8'h13, 8'h13);
    wr(32'h0001_0203, 4);
    chk({3'h0, a}, 8'h1e);
    rdp(8'h00, 8'h33, 8'h15);
    mux_in <= 5'h0c;
    sel1 <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr({ovr[i], 8'h05, 16'h0}, 2);
      chk({3'h0, a}, 8'h18);
      outs(ovx[i], ovb[i]);
    end
    sel0 <= 1'b1;
    outs(5'h0c, 1'b0);
    sel1 <= 1'b1;
    outs(5'h0c, 1'b0);
    sel0 <= 1'b0;
    outs(5'h13, 1'b1);
    stop_test();
  end
endmodule : test_dsw_top
